// File: pkg/wpp_params.svh
// Constants for the weld program panel controller: offsets, fields, resets, timing.
`ifndef WPP_PARAMS_SVH
`define WPP_PARAMS_SVH

`define WPP_PROG_COUNT 5'h13
`define WPP_PROG_LAST 5'h12
`define WPP_TIMER_COUNT 4

`define WPP_REG_CTRL 8'h00
`define WPP_REG_STATUS 8'h04
`define WPP_REG_DIFF 8'h08
`define WPP_REG_DISPLAY 8'h0C
`define WPP_CTRL_LOCK_BIT 0
`define WPP_CTRL_ABORT_BIT 1
`define WPP_CTRL_RESET 1'h0

`define WPP_FEAT_VERT_BIT 4
`define WPP_FEAT_HORIZ_BIT 5
`define WPP_FEAT_LOCKOUT_BIT 6
`define WPP_FEAT_CRATER_BIT 7

`define WPP_TENTH_MS 100
`define WPP_CLK_KHZ 200000
`define WPP_FIXED_DELAY_TENTHS 16'h0019
`define WPP_BLANK_TENTHS 3'h3
`define WPP_FLASH_TENTHS 3'h3
`define WPP_FLASH_STEPS 3'h4

// Factory program store, program 1 in the lowest slice
`define WPP_DFLT_WELD 16'h0600
`define WPP_DFLT_FEAT {8'hBF, 8'h83, 8'h8F, 8'hC2, 8'h86, 8'hBE, 8'hB6, 8'h8E, 8'hB7, \
   8'h8D, 8'hBD, 8'h8C, 8'h84, 8'hC0, 8'hB4, 8'h00, 8'hBC, 8'hB5, 8'h81}
`define WPP_DFLT_OVER {16'h0010, 16'h0000, 16'h0000, 16'h0030, 16'h0000, 16'h0000, \
   16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0005, 16'h0000, 16'h0000, 16'h0020, \
   16'h0000, 16'h0050, 16'h0000, 16'h0000, 16'h0000}
`define WPP_DFLT_FINAL {{15{16'h0050}}, 16'h0040, 16'h0030, 16'h0020, 16'h0010}
`define WPP_DFLT_RETR {{12{16'h0050}}, 16'h0100, 16'h0050, 16'h0040, 16'h0030, \
   16'h0020, 16'h0010, 16'h0005}

`endif

// File: pkg/wpp_pkg.sv
// Types and helper functions for the weld program panel controller.
package wpp_pkg;

   typedef enum logic [2:0] {
      POS_WELD = 3'b000,
      POS_OVER = 3'b001,
      POS_FINAL = 3'b010,
      POS_RETR = 3'b011,
      POS_PROG = 3'b100
   } wpp_pos_type;

   typedef enum logic [1:0] {
      PST_EDIT = 2'b00,
      PST_BLANK = 2'b01,
      PST_FLASH = 2'b10
   } wpp_pst_type;

   typedef enum logic [2:0] {
      CYC_IDLE = 3'b000,
      CYC_LOCK = 3'b001,
      CYC_WELD = 3'b010,
      CYC_OVER = 3'b011,
      CYC_FINAL = 3'b100,
      CYC_CRATER = 3'b101,
      CYC_RETR = 3'b110
   } wpp_cyc_type;

   typedef struct packed {
      logic [7:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } wpp_apb_req_type;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } wpp_apb_rsp_type;

   typedef struct packed {
      logic [15:0] digits;
      logic [27:0] segments;
      logic blank;
      logic [4:0] leds;
      logic features_led;
      logic [7:0] feature_diff;
   } wpp_panel_type;

   typedef struct packed {
      wpp_cyc_type phase;
      logic [7:0] features;
      logic lockout_hold;
      logic crater_wait;
   } wpp_cycle_type;

   function automatic logic [6:0] wpp_seg7(input logic [3:0] d);
      case (d)
         4'h0: wpp_seg7 = 7'h3F;
         4'h1: wpp_seg7 = 7'h06;
         4'h2: wpp_seg7 = 7'h5B;
         4'h3: wpp_seg7 = 7'h4F;
         4'h4: wpp_seg7 = 7'h66;
         4'h5: wpp_seg7 = 7'h6D;
         4'h6: wpp_seg7 = 7'h7D;
         4'h7: wpp_seg7 = 7'h07;
         4'h8: wpp_seg7 = 7'h7F;
         4'h9: wpp_seg7 = 7'h6F;
         default: wpp_seg7 = 7'h00;
      endcase
   endfunction : wpp_seg7

endpackage : wpp_pkg

// File: hw/wpp_panel_ctrl.sv
// Weld program panel controller: program store, panel editing and timer countdown.
// Functional notes
// - The vertical and horizontal delay enables follow the switches captured at a confirmed store.
// - The settling lockout enable follows its switch captured at a confirmed store.
// - With crater fill enabled a two second wait sits between final and retract, else none.
// - Nineteen programs are held and the program number is edited from 1 to 19.
// - From weld time onward the running timer counts down on the display with its LED lit; the crater wait counts down with no LED.
// - Select steps weld, overlap, final, retract, program and round again, LED following.
// - The program LED is lit while the display shows the program number.
// - Moving onto a timer shows that timer's stored value for the selected program.
// - Four digit buttons each bump one digit; only the right two act on the program number.
// - A program press stores the shown timer, blanks briefly, then flashes each value.
// - The first press after a switch change flags differing features on the features LED.
// - The next press commits the switch features together with the shown timer value.
// - Differences track the switches live between presses and commit only on the confirm.
// - Each program keeps its own feature set, untouched by edits of another.
// - With lockout enabled the slides stay manual two seconds after the start relay.
//
// The register addresses and the APB register port are this design's own decisions.
`include "wpp_params.svh"
`timescale 1ns/1ps
`default_nettype none
module wpp_panel_ctrl
   import wpp_pkg::*;
#(
   parameter int TENTH_CYCLES = `WPP_TENTH_MS * `WPP_CLK_KHZ
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire wpp_apb_req_type apb_req,
   output wpp_apb_rsp_type apb_rsp,
   input wire logic select_btn_pin,
   input wire logic [3:0] digit_btn_pin,
   input wire logic program_btn_pin,
   input wire logic start_relay_pin,
   input wire logic [7:0] feature_switch_bank,
   output wpp_panel_type panel,
   output wpp_cycle_type cycle
);

   localparam int NPIN = 15;
   localparam logic [24:0] TENTH_LAST = 25'(TENTH_CYCLES - 1);

   // Pin synchroniser, three stages, change accepted when stages two and three agree
   logic [NPIN-1:0] pins;
   logic [NPIN-1:0] s1_q, s2_q, s3_q, stb_q, prv_q, stb_d;
   assign pins = {feature_switch_bank, start_relay_pin, program_btn_pin, digit_btn_pin,
                  select_btn_pin};

   always_comb begin
      stb_d = (s2_q & s3_q) | (stb_q & (s2_q ^ s3_q));
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         stb_q <= '0;
         prv_q <= '0;
      end else begin
         s1_q <= pins;
         s2_q <= s1_q;
         s3_q <= s2_q;
         stb_q <= stb_d;
         prv_q <= stb_q;
      end
   end

   logic sel_press, prog_press, start_rise;
   logic [3:0] dig_press;
   logic [7:0] sw_feat;
   assign sel_press = stb_q[0] & ~prv_q[0];
   assign dig_press = stb_q[4:1] & ~prv_q[4:1];
   assign prog_press = stb_q[5] & ~prv_q[5];
   assign start_rise = stb_q[6] & ~prv_q[6];
   assign sw_feat = stb_q[14:7];

   // Tenth-second tick shared by countdown and flash timing
   logic [24:0] tick_cnt_q, tick_cnt_d;
   logic tick;
   assign tick = (tick_cnt_q == TENTH_LAST);
   always_comb begin
      tick_cnt_d = tick ? 25'h0000000 : tick_cnt_q + 25'h0000001;
   end

   // Register bus state
   logic lock_q, lock_d, abort_q, abort_d, miss_q, miss_d;
   logic [31:0] rdata_q, rdata_d;

   // Program store and panel state
   logic [15:0] tmr_q [`WPP_PROG_COUNT][`WPP_TIMER_COUNT];
   logic [15:0] tmr_d [`WPP_PROG_COUNT][`WPP_TIMER_COUNT];
   logic [7:0] feat_q [`WPP_PROG_COUNT];
   logic [7:0] feat_d [`WPP_PROG_COUNT];
   wpp_pos_type pos_q, pos_d;
   wpp_pst_type pst_q, pst_d;
   logic [4:0] idx_q, idx_d;
   logic [15:0] edit_q, edit_d;
   logic pend_q, pend_d;
   logic [2:0] pcnt_q, pcnt_d, step_q, step_d;
   wpp_cyc_type cyc_q, cyc_d;
   logic [15:0] rem_q, rem_d;
   wpp_panel_type panel_d;
   wpp_cycle_type cycle_d;
   logic [7:0] feat_diff;
   logic [7:0] cur_feat;

   assign cur_feat = feat_q[idx_q];
   assign feat_diff = sw_feat ^ cur_feat;

   function automatic logic [15:0] prog_bcd(input logic [4:0] i);
      logic [4:0] n;
      n = i + 5'h01;
      prog_bcd = (n >= 5'h0A) ? {8'h00, 4'h1, 4'(n - 5'h0A)} : {12'h000, n[3:0]};
   endfunction : prog_bcd

   function automatic logic [15:0] bcd_dec(input logic [15:0] v);
      logic [15:0] r;
      logic borrow;
      r = v;
      borrow = 1'b1;
      for (int k = 0; k < 4; k++) begin
         if (borrow) begin
            borrow = (v[4*k +: 4] == 4'h0);
            r[4*k +: 4] = borrow ? 4'h9 : v[4*k +: 4] - 4'h1;
         end
      end
      bcd_dec = r;
   endfunction : bcd_dec

   function automatic logic [15:0] bcd_bump(input logic [15:0] v, input logic [3:0] which);
      logic [15:0] r;
      r = v;
      for (int k = 0; k < 4; k++) begin
         if (which[k]) begin
            r[4*k +: 4] = (v[4*k +: 4] >= 4'h9) ? 4'h0 : v[4*k +: 4] + 4'h1;
         end
      end
      bcd_bump = r;
   endfunction : bcd_bump

   // Panel editing, store and flash sequence
   always_comb begin
      logic [4:0] n;
      logic [3:0] u;
      logic t;
      n = idx_q + 5'h01;
      u = (n >= 5'h0A) ? 4'(n - 5'h0A) : n[3:0];
      t = (n >= 5'h0A);
      tmr_d = tmr_q;
      feat_d = feat_q;
      pos_d = pos_q;
      idx_d = idx_q;
      edit_d = edit_q;
      pend_d = pend_q;
      pst_d = pst_q;
      pcnt_d = pcnt_q;
      step_d = step_q;
      case (pst_q)
         PST_EDIT: begin
            if (!lock_q && cyc_q == CYC_IDLE) begin
               if (sel_press) begin
                  case (pos_q)
                     POS_WELD: pos_d = POS_OVER;
                     POS_OVER: pos_d = POS_FINAL;
                     POS_FINAL: pos_d = POS_RETR;
                     POS_RETR: pos_d = POS_PROG;
                     default: pos_d = POS_WELD;
                  endcase
                  edit_d = (pos_d == POS_PROG) ? prog_bcd(idx_q) : tmr_q[idx_q][pos_d[1:0]];
               end else if (|dig_press) begin
                  if (pos_q == POS_PROG) begin
                     if (dig_press[0]) u = (u >= 4'h9) ? 4'h0 : u + 4'h1;
                     if (dig_press[1]) t = ~t;
                     n = t ? 5'h0A + {1'b0, u} : {1'b0, u};
                     // Out-of-range numbers fold back to program 1
                     idx_d = (n == 5'h00 || n > `WPP_PROG_COUNT) ? 5'h00 : n - 5'h01;
                     edit_d = prog_bcd(idx_d);
                     pend_d = 1'b0;
                  end else begin
                     edit_d = bcd_bump(edit_q, dig_press);
                  end
               end else if (prog_press) begin
                  if (pos_q != POS_PROG) tmr_d[idx_q][pos_q[1:0]] = edit_q;
                  if (pend_q) begin
                     feat_d[idx_q] = sw_feat;
                     pend_d = 1'b0;
                  end else if (|feat_diff) begin
                     pend_d = 1'b1;
                  end
                  pst_d = PST_BLANK;
                  pcnt_d = 3'h0;
               end
            end
         end
         PST_BLANK: begin
            if (tick) begin
               pcnt_d = pcnt_q + 3'h1;
               if (pcnt_q == `WPP_BLANK_TENTHS - 3'h1) begin
                  pst_d = PST_FLASH;
                  pcnt_d = 3'h0;
                  step_d = 3'h0;
               end
            end
         end
         PST_FLASH: begin
            if (tick) begin
               pcnt_d = pcnt_q + 3'h1;
               if (pcnt_q == `WPP_FLASH_TENTHS - 3'h1) begin
                  pcnt_d = 3'h0;
                  step_d = step_q + 3'h1;
                  if (step_q == `WPP_FLASH_STEPS) pst_d = PST_EDIT;
               end
            end
         end
         default: pst_d = PST_EDIT;
      endcase
   end

   // Weld cycle timing and countdown
   always_comb begin
      cyc_d = cyc_q;
      rem_d = rem_q;
      if (abort_q) begin
         cyc_d = CYC_IDLE;
         rem_d = 16'h0000;
      end else if (cyc_q == CYC_IDLE) begin
         if (start_rise && pst_q == PST_EDIT) begin
            if (cur_feat[`WPP_FEAT_LOCKOUT_BIT]) begin
               cyc_d = CYC_LOCK;
               rem_d = `WPP_FIXED_DELAY_TENTHS;
            end else begin
               cyc_d = CYC_WELD;
               rem_d = tmr_q[idx_q][2'h0];
            end
         end
      end else if (tick) begin
         if (rem_q != 16'h0000) begin
            rem_d = bcd_dec(rem_q);
         end else begin
            case (cyc_q)
               CYC_LOCK: begin
                  cyc_d = CYC_WELD;
                  rem_d = tmr_q[idx_q][2'h0];
               end
               CYC_WELD: begin
                  cyc_d = CYC_OVER;
                  rem_d = tmr_q[idx_q][2'h1];
               end
               CYC_OVER: begin
                  cyc_d = CYC_FINAL;
                  rem_d = tmr_q[idx_q][2'h2];
               end
               CYC_FINAL: begin
                  if (cur_feat[`WPP_FEAT_CRATER_BIT]) begin
                     cyc_d = CYC_CRATER;
                     rem_d = `WPP_FIXED_DELAY_TENTHS;
                  end else begin
                     cyc_d = CYC_RETR;
                     rem_d = tmr_q[idx_q][2'h3];
                  end
               end
               CYC_CRATER: begin
                  cyc_d = CYC_RETR;
                  rem_d = tmr_q[idx_q][2'h3];
               end
               default: cyc_d = CYC_IDLE;
            endcase
         end
      end
   end

   // Display and indicator selection
   always_comb begin
      logic [15:0] shown;
      logic [2:0] fpos;
      shown = edit_q;
      fpos = step_q;
      panel_d.blank = 1'b0;
      panel_d.leds = 5'h00;
      if (cyc_q >= CYC_WELD) begin
         shown = rem_q;
         case (cyc_q)
            CYC_WELD: panel_d.leds = 5'h01;
            CYC_OVER: panel_d.leds = 5'h02;
            CYC_FINAL: panel_d.leds = 5'h04;
            CYC_RETR: panel_d.leds = 5'h08;
            default: panel_d.leds = 5'h00;
         endcase
      end else if (pst_q == PST_BLANK) begin
         panel_d.blank = 1'b1;
         shown = 16'h0000;
      end else if (pst_q == PST_FLASH) begin
         // Step four flashes the feature set, shown as a raw byte
         shown = (fpos == `WPP_FLASH_STEPS) ? {8'h00, cur_feat} : tmr_q[idx_q][fpos[1:0]];
         panel_d.leds = 5'(5'h01 << fpos);
      end else begin
         panel_d.leds = 5'(5'h01 << pos_q);
      end
      panel_d.digits = shown;
      for (int k = 0; k < 4; k++) begin
         panel_d.segments[7*k +: 7] = panel_d.blank ? 7'h00 : wpp_seg7(shown[4*k +: 4]);
      end
      panel_d.features_led = pend_q & (|feat_diff);
      panel_d.feature_diff = pend_q ? feat_diff : 8'h00;
      cycle_d.phase = cyc_q;
      cycle_d.features = cur_feat;
      cycle_d.lockout_hold = (cyc_q == CYC_LOCK);
      cycle_d.crater_wait = (cyc_q == CYC_CRATER);
   end

   // Register bus: zero wait, read data captured in the setup cycle
   always_comb begin
      logic setup, wr;
      setup = apb_req.psel & ~apb_req.penable;
      wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
      lock_d = lock_q;
      abort_d = 1'b0;
      miss_d = miss_q;
      rdata_d = rdata_q;
      if (setup) begin
         miss_d = 1'b0;
         rdata_d = 32'h00000000;
         case (apb_req.paddr)
            `WPP_REG_CTRL: rdata_d = {31'h00000000, lock_q};
            `WPP_REG_STATUS: rdata_d = {19'h00000, (pst_q != PST_EDIT), pend_q, cyc_q, pos_q, idx_q};
            `WPP_REG_DIFF: rdata_d = {24'h000000, feat_diff};
            `WPP_REG_DISPLAY: rdata_d = {16'h0000, panel.digits};
            default: miss_d = 1'b1;
         endcase
      end
      if (wr && apb_req.paddr == `WPP_REG_CTRL) begin
         lock_d = apb_req.pwdata[`WPP_CTRL_LOCK_BIT];
         abort_d = apb_req.pwdata[`WPP_CTRL_ABORT_BIT];
      end
   end

   assign apb_rsp.prdata = rdata_q;
   assign apb_rsp.pready = 1'b1;
   assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & miss_q;

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         tick_cnt_q <= 25'h0000000;
         lock_q <= `WPP_CTRL_RESET;
         abort_q <= 1'b0;
         miss_q <= 1'b0;
         rdata_q <= 32'h00000000;
         // No retention element here; every reset reloads the factory store
         for (int p = 0; p < `WPP_PROG_COUNT; p++) begin
            tmr_q[p][0] <= `WPP_DFLT_WELD;
            tmr_q[p][1] <= 16'(`WPP_DFLT_OVER >> (16 * p));
            tmr_q[p][2] <= 16'(`WPP_DFLT_FINAL >> (16 * p));
            tmr_q[p][3] <= 16'(`WPP_DFLT_RETR >> (16 * p));
            feat_q[p] <= 8'(`WPP_DFLT_FEAT >> (8 * p));
         end
         pos_q <= POS_PROG;
         pst_q <= PST_EDIT;
         idx_q <= 5'h00;
         edit_q <= 16'h0001;
         pend_q <= 1'b0;
         pcnt_q <= 3'h0;
         step_q <= 3'h0;
         cyc_q <= CYC_IDLE;
         rem_q <= 16'h0000;
         panel <= '0;
         cycle <= '0;
      end else begin
         tick_cnt_q <= tick_cnt_d;
         lock_q <= lock_d;
         abort_q <= abort_d;
         miss_q <= miss_d;
         rdata_q <= rdata_d;
         tmr_q <= tmr_d;
         feat_q <= feat_d;
         pos_q <= pos_d;
         pst_q <= pst_d;
         idx_q <= idx_d;
         edit_q <= edit_d;
         pend_q <= pend_d;
         pcnt_q <= pcnt_d;
         step_q <= step_d;
         cyc_q <= cyc_d;
         rem_q <= rem_d;
         panel <= panel_d;
         cycle <= cycle_d;
      end
   end

endmodule : wpp_panel_ctrl
`default_nettype wire

// File: verif/wpp_panel_props.sv
// Port-level assertions for the weld program panel controller.
`timescale 1ns/1ps
`default_nettype none
module wpp_panel_props
   import wpp_pkg::*;
#(
   parameter int TENTH_CYCLES = 20
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire wpp_apb_req_type apb_req,
   input wire wpp_apb_rsp_type apb_rsp,
   input wire logic select_btn_pin,
   input wire logic [3:0] digit_btn_pin,
   input wire logic program_btn_pin,
   input wire logic start_relay_pin,
   input wire logic [7:0] feature_switch_bank,
   input wire wpp_panel_type panel,
   input wire wpp_cycle_type cycle
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   localparam int CRATER_MIN = 20 * TENTH_CYCLES;
   localparam int CRATER_MAX = 21 * TENTH_CYCLES;
   int crater_cnt_q;
   int crater_cnt_d;
   // Crater length is counted, too long for a delay range
   always_comb begin
      crater_cnt_d = (cycle.phase == CYC_CRATER) ? crater_cnt_q + 1 : 0;
   end
   always_ff @(posedge ref_clk) begin
      crater_cnt_q <= resetn ? crater_cnt_d : 0;
   end
   sequence s_cycle_start;
      $past(cycle.phase) == CYC_IDLE && cycle.phase != CYC_IDLE;
   endsequence
   // Idle excluded: abort may cut any phase short
   sequence s_final_left;
      $past(cycle.phase) == CYC_FINAL && cycle.phase != CYC_FINAL && cycle.phase != CYC_IDLE;
   endsequence
   sequence s_crater_left;
      $past(cycle.phase) == CYC_CRATER && cycle.phase != CYC_CRATER && cycle.phase != CYC_IDLE;
   endsequence
   AST_START_PATH: assert property (
      s_cycle_start |-> cycle.phase == ($past(cycle.features[6]) ? CYC_LOCK : CYC_WELD))
      else $error("cycle started in the wrong phase");
   AST_LOCK_HOLD: assert property (
      cycle.lockout_hold == (cycle.phase == CYC_LOCK))
      else $error("slides not held during lockout");
   AST_CRATER_PATH: assert property (
      s_final_left |-> cycle.phase == ($past(cycle.features[7]) ? CYC_CRATER : CYC_RETR))
      else $error("final phase left to the wrong successor");
   AST_CRATER_WAIT: assert property (
      cycle.crater_wait == (cycle.phase == CYC_CRATER))
      else $error("crater wait flag low in crater phase");
   AST_CRATER_BOUND: assert property (
      cycle.phase == CYC_CRATER |-> crater_cnt_q < CRATER_MAX)
      else $error("crater wait runs too long");
   AST_CRATER_LEN: assert property (
      s_crater_left |-> crater_cnt_q >= CRATER_MIN && crater_cnt_q <= CRATER_MAX)
      else $error("crater wait of wrong length");
   AST_ONE_LED: assert property (
      $onehot0(panel.leds))
      else $error("more than one position led lit");
   AST_BLANK_SEG: assert property (
      panel.blank |-> panel.segments == 28'h0)
      else $error("segments lit while blank");
   AST_WELD_LED: assert property (
      cycle.phase == CYC_WELD && $past(cycle.phase) == CYC_WELD |-> panel.leds == 5'h01)
      else $error("weld led not lit during weld");
   AST_COUNT_DOWN: assert property (
      (cycle.phase == CYC_WELD) [*3] |-> panel.digits <= $past(panel.digits))
      else $error("weld countdown went up");
   AST_FEAT_LED: assert property (
      panel.features_led |-> panel.feature_diff != 8'h00)
      else $error("features led lit with no difference");
endmodule : wpp_panel_props

bind wpp_panel_ctrl wpp_panel_props #(.TENTH_CYCLES(TENTH_CYCLES)) wpp_panel_props_inst (
   .ref_clk(ref_clk), .resetn(resetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
   .select_btn_pin(select_btn_pin), .digit_btn_pin(digit_btn_pin),
   .program_btn_pin(program_btn_pin), .start_relay_pin(start_relay_pin),
   .feature_switch_bank(feature_switch_bank), .panel(panel), .cycle(cycle));
`default_nettype wire

// File: verif/wpp_operator.sv
// Operator model: panel buttons, start relay and feature switches.
`timescale 1ns/1ps
`default_nettype none
module wpp_operator (
   input wire logic ref_clk,
   output logic select_btn_pin,
   output logic [3:0] digit_btn_pin,
   output logic program_btn_pin,
   output logic start_relay_pin,
   output logic [7:0] feature_switch_bank
);
   initial begin
      select_btn_pin = 1'b0;
      digit_btn_pin = 4'h0;
      program_btn_pin = 1'b0;
      start_relay_pin = 1'b0;
      feature_switch_bank = 8'h8E;
   end
   // Key 0..3 digit, 4 select, 5 program, 6 start; held well past the input filter
   task automatic press(input int key);
      @(posedge ref_clk);
      if (key < 4) digit_btn_pin[key] <= 1'b1;
      else if (key == 4) select_btn_pin <= 1'b1;
      else if (key == 5) program_btn_pin <= 1'b1;
      else start_relay_pin <= 1'b1;
      repeat (6) @(posedge ref_clk);
      digit_btn_pin <= 4'h0;
      select_btn_pin <= 1'b0;
      program_btn_pin <= 1'b0;
      start_relay_pin <= 1'b0;
      repeat (6) @(posedge ref_clk);
   endtask : press
   task automatic set_sw(input logic [7:0] sw);
      @(posedge ref_clk);
      feature_switch_bank <= sw;
      repeat (8) @(posedge ref_clk);
   endtask : set_sw
endmodule : wpp_operator
`default_nettype wire

// File: verif/testbench.sv
// Self-checking testbench for the weld program panel controller.
`include "wpp_params.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench
   import wpp_pkg::*;
;
   localparam int TENTH = 20;
   localparam int LIMIT = 50000;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   wpp_apb_req_type apb_req = '0;
   wpp_apb_rsp_type apb_rsp;
   wpp_panel_type panel;
   wpp_cycle_type cycle;
   logic select_btn_pin;
   logic [3:0] digit_btn_pin;
   logic program_btn_pin;
   logic start_relay_pin;
   logic [7:0] feature_switch_bank;
   int mismatches = 0;
   int n_checks = 0;
   int cyc = 0;
   int crater_cycles = 0;
   int i;
   logic saw_blank = 1'b0;
   logic [31:0] rd;
   logic err;
   logic [4:0] sel_led [5] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10};
   // Factory values of program 1
   logic [15:0] sel_dig [5] = '{16'h0600, 16'h0000, 16'h0010, 16'h0005, 16'h0001};

   wpp_panel_ctrl #(.TENTH_CYCLES(TENTH)) wpp_panel_ctrl_inst (
      .ref_clk(ref_clk), .resetn(resetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
      .select_btn_pin(select_btn_pin), .digit_btn_pin(digit_btn_pin),
      .program_btn_pin(program_btn_pin), .start_relay_pin(start_relay_pin),
      .feature_switch_bank(feature_switch_bank), .panel(panel), .cycle(cycle));
   wpp_operator wpp_operator_inst (
      .ref_clk(ref_clk), .select_btn_pin(select_btn_pin), .digit_btn_pin(digit_btn_pin),
      .program_btn_pin(program_btn_pin), .start_relay_pin(start_relay_pin),
      .feature_switch_bank(feature_switch_bank));

   always #2.5 ref_clk = ~ref_clk;

   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : test_done

   always @(posedge ref_clk) begin
      cyc = cyc + 1;
      if (panel.blank === 1'b1) saw_blank = 1'b1;
      if (cycle.phase === CYC_CRATER && cycle.crater_wait === 1'b1)
         crater_cycles = crater_cycles + 1;
      if (cyc == LIMIT) begin
         mismatches = mismatches + 1;
         test_done();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge ref_clk);
      apb_req.paddr <= a;
      apb_req.pwrite <= w;
      apb_req.pwdata <= wd;
      apb_req.psel <= 1'b1;
      apb_req.penable <= 1'b0;
      @(posedge ref_clk);
      apb_req.penable <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (apb_rsp.pready !== 1'b1);
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask : apb

   task automatic wait_busy;
      do begin
         apb(1'b0, `WPP_REG_STATUS, 32'h0);
      end while (rd[12] !== 1'b0);
   endtask : wait_busy

   task automatic wait_phase(input wpp_cyc_type p);
      while (cycle.phase !== p) @(posedge ref_clk);
   endtask : wait_phase

   initial begin
      repeat (16) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (8) @(posedge ref_clk);
      chk(panel.leds, 5'h10);
      chk(panel.digits, 16'h0001);
      chk(panel.segments, 28'h7EFDF86);
      apb(1'b0, `WPP_REG_STATUS, 32'h0);
      chk(rd, 32'h80);
      apb(1'b1, `WPP_REG_STATUS, 32'hFFFF_FFFF);
      apb(1'b0, `WPP_REG_STATUS, 32'h0);
      chk(rd, 32'h80);
      apb(1'b0, 8'h10, 32'h0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
      // Panel lock must swallow a select press
      apb(1'b1, `WPP_REG_CTRL, 32'h1);
      wpp_operator_inst.press(4);
      chk(panel.leds, 5'h10);
      apb(1'b1, `WPP_REG_CTRL, 32'h0);
      $display("test reset and registers done");
      for (i = 0; i < 5; i++) begin
         wpp_operator_inst.press(4);
         chk(panel.leds, sel_led[i]);
         chk(panel.digits, sel_dig[i]);
      end
      $display("test select walk done");
      wpp_operator_inst.press(1);
      chk(panel.digits, 16'h0011);
      for (i = 0; i < 8; i++) wpp_operator_inst.press(0);
      chk(panel.digits, 16'h0019);
      wpp_operator_inst.press(0);
      wpp_operator_inst.press(1);
      chk(panel.digits, 16'h0001);
      wpp_operator_inst.press(3);
      wpp_operator_inst.press(2);
      wpp_operator_inst.press(1);
      wpp_operator_inst.press(0);
      chk(panel.digits, 16'h0012);
      chk(panel.leds, 5'h10);
      wpp_operator_inst.press(4);
      apb(1'b0, `WPP_REG_STATUS, 32'h0);
      chk(rd[7:0], 8'h0B);
      chk(cycle.features, 8'h8E);
      $display("test program number done");
      wpp_operator_inst.set_sw(8'h9E);
      apb(1'b0, `WPP_REG_DIFF, 32'h0);
      chk(rd, 32'h10);
      wpp_operator_inst.press(0);
      wpp_operator_inst.press(5);
      chk(panel.features_led, 1'b1);
      chk(panel.feature_diff, 8'h10);
      wait_busy();
      chk(saw_blank, 1'b1);
      chk(cycle.features, 8'h8E);
      wpp_operator_inst.set_sw(8'h71);
      apb(1'b0, `WPP_REG_DIFF, 32'h0);
      chk(rd, 32'hFF);
      wpp_operator_inst.set_sw(8'hFE);
      apb(1'b0, `WPP_REG_DIFF, 32'h0);
      chk(rd, 32'h70);
      chk(panel.features_led, 1'b1);
      wpp_operator_inst.press(5);
      wait_busy();
      chk(cycle.features, 8'hFE);
      chk(panel.features_led, 1'b0);
      apb(1'b0, `WPP_REG_DISPLAY, 32'h0);
      chk(rd, 32'h0601);
      for (i = 0; i < 4; i++) wpp_operator_inst.press(4);
      wpp_operator_inst.press(1);
      chk(cycle.features, 8'hB5);
      wpp_operator_inst.press(1);
      chk(cycle.features, 8'hFE);
      $display("test feature store done");
      wpp_operator_inst.press(6);
      chk(cycle.phase, CYC_LOCK);
      chk(cycle.lockout_hold, 1'b1);
      wait_phase(CYC_WELD);
      repeat (300) @(posedge ref_clk);
      chk(panel.leds, 5'h01);
      chk(panel.digits < 16'h0601, 1'b1);
      wait_phase(CYC_FINAL);
      repeat (2) @(posedge ref_clk);
      chk(panel.leds, 5'h04);
      wait_phase(CYC_RETR);
      chk(crater_cycles >= 20 * TENTH && crater_cycles <= 21 * TENTH, 1'b1);
      wait_phase(CYC_IDLE);
      $display("test cycle with lockout and crater done");
      wpp_operator_inst.press(1);
      wpp_operator_inst.press(0);
      wpp_operator_inst.press(0);
      chk(cycle.features, 8'h00);
      crater_cycles = 0;
      wpp_operator_inst.press(6);
      chk(cycle.phase, CYC_WELD);
      wait_phase(CYC_RETR);
      chk(crater_cycles, 0);
      apb(1'b1, `WPP_REG_CTRL, 32'h2);
      repeat (3) @(posedge ref_clk);
      chk(cycle.phase, CYC_IDLE);
      $display("test plain cycle done");
      test_done();
   end
endmodule : testbench
`default_nettype wire
